// >>> hw/fp_assist_exception_entry.sv
// entry sequencer of the floating-point assist exception, with a wishbone register slave
// assumes the core holds next_pc_i and machine_state_word_i valid while a request is up
//
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "fpa_map.svh"
module fp_assist_exception_entry
  import fpa_pkg::*;
#(
  parameter bit FPA_PRESENT = 1'b1,
  parameter int ADDR_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic fp_assist_req_i,
  input wire logic fp_unimpl_req_i,
  input wire logic instr_boundary_i,
  input wire logic [31:0] next_pc_i,
  input wire logic [31:0] machine_state_word_i,
  input wire logic [9:0] impl_info_i,
  output logic fp_hold_o,
  output logic illegal_exc_o,
  output logic msw_load_o,
  output logic [31:0] msw_new_o,
  output logic [31:0] saved_return_address_o,
  output logic [31:0] saved_machine_state_o,
  output logic fetch_redirect_o,
  output logic [31:0] fetch_addr_o
);
  entry_regs_t s;
  entry_regs_t n;
  fpa_rw_if rw ();
  logic enabled;
  logic req_any;
  logic take;
  logic to_illegal;
  logic bus_req;
  logic bus_wr;
  logic [7:0] reg_adr;
  logic [31:0] lane;
  logic [1:0] st_set;
  logic [1:0] st_clr;

  fpa_state_rewrite u_rewrite (
    .rw(rw)
  );

  assign rw.msw = s.cap_msw;
  assign rw.impl = s.cap_impl;

  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    return m;
  endfunction

  always_comb begin
    enabled = FPA_PRESENT && s.ctrl[`FPA_CTRL_EN];
    // the core drops its request only at the edge after the illegal pulse, so that cycle is ignored
    req_any = enabled && !s.illegal && (fp_assist_req_i || fp_unimpl_req_i);
    // an unimplemented instruction goes illegal only when software asks and no assist case is up
    to_illegal = enabled && !s.illegal && instr_boundary_i && fp_unimpl_req_i && !fp_assist_req_i
                 && s.ctrl[`FPA_CTRL_ILL];
    take = enabled && !s.illegal && instr_boundary_i && !to_illegal
           && (fp_assist_req_i || fp_unimpl_req_i);
    bus_req = wb_cyc_i && wb_stb_i && !s.ack;
    bus_wr = bus_req && wb_we_i;
    reg_adr = {wb_adr_i[7:2], 2'h0};
    lane = lane_mask(wb_sel_i);
    st_set = 2'h0;
    st_clr = 2'h0;
    n = s;
    n.msw_load = 1'b0;
    n.redirect = 1'b0;
    n.illegal = 1'b0;
    n.ack = bus_req;
    n.dat = 32'h00000000;
    if (bus_req && !wb_we_i) begin
      case (reg_adr)
        `FPA_REG_CTRL: n.dat = {30'h0, s.ctrl};
        `FPA_REG_STATUS: n.dat = {30'h0, s.status};
        `FPA_REG_MASK: n.dat = {30'h0, s.mask};
        `FPA_REG_RET: n.dat = s.ret;
        `FPA_REG_SAVED: n.dat = s.saved;
        `FPA_REG_VECTOR: n.dat = s.fetch_addr;
        default: n.dat = 32'h00000000;
      endcase
    end
    if (bus_wr) begin
      case (reg_adr)
        `FPA_REG_CTRL: if (wb_sel_i[0]) n.ctrl = wb_dat_i[1:0];
        `FPA_REG_STATUS: if (wb_sel_i[0]) st_clr = wb_dat_i[1:0];
        `FPA_REG_MASK: if (wb_sel_i[0]) n.mask = wb_dat_i[1:0];
        `FPA_REG_RET: n.ret = (s.ret & ~lane) | (wb_dat_i & lane);
        `FPA_REG_SAVED: n.saved = (s.saved & ~lane) | (wb_dat_i & lane);
        default: n.dat = 32'h00000000;
      endcase
    end
    case (s.st)
      ST_IDLE: begin
        // hold the faulting instruction off the float state until entry completes
        n.hold = req_any && !to_illegal;
        if (take) begin
          n.st = ST_SAVE;
          n.cap_pc = next_pc_i;
          n.cap_msw = machine_state_word_i;
          n.cap_impl = impl_info_i;
        end else if (to_illegal) begin
          n.illegal = 1'b1;
          st_set[`FPA_ST_ILL] = 1'b1;
        end
      end
      ST_SAVE: begin
        // hardware save wins over a software write in the same cycle
        n.ret = s.cap_pc;
        n.saved = rw.saved;
        n.msw_new = rw.new_msw;
        n.msw_load = 1'b1;
        n.st = ST_REDIRECT;
      end
      ST_REDIRECT: begin
        n.fetch_addr = rw.vec;
        n.redirect = 1'b1;
        n.hold = 1'b0;
        n.st = ST_IDLE;
        st_set[`FPA_ST_TAKEN] = 1'b1;
      end
      default: begin
        n.st = ST_IDLE;
        n.hold = 1'b0;
      end
    endcase
    // a new event beats a write-one clear in the same cycle
    n.status = (s.status & ~st_clr) | st_set;
    n.irq = |(n.status & n.mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.ctrl <= `FPA_CTRL_RST;
    end else if (ce_i) begin
      s <= n;
    end
  end

  assign wb_dat_o = s.dat;
  assign wb_ack_o = s.ack;
  assign irq_o = s.irq;
  assign fp_hold_o = s.hold;
  assign illegal_exc_o = s.illegal;
  assign msw_load_o = s.msw_load;
  assign msw_new_o = s.msw_new;
  assign saved_return_address_o = s.ret;
  assign saved_machine_state_o = s.saved;
  assign fetch_redirect_o = s.redirect;
  assign fetch_addr_o = s.fetch_addr;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i || !ce_i);

  sequence s_take;
    s.st == ST_IDLE && take;
  endsequence

  sequence s_saved;
    msw_load_o ##1 fetch_redirect_o;
  endsequence

  AST_ABSENT: assert property ((s.st == ST_IDLE && !enabled) |=> s.st == ST_IDLE)
    else $error("entry started while the assist exception is off");
  AST_TAKE: assert property ((s.st == ST_IDLE && enabled && !illegal_exc_o && instr_boundary_i && fp_assist_req_i)
    |=> s.st == ST_SAVE)
    else $error("assist request at a boundary did not start entry");
  AST_ILLEGAL: assert property (to_illegal |=> illegal_exc_o && s.st == ST_IDLE && !msw_load_o)
    else $error("illegal-instruction choice not honoured");
  AST_ILL_ONCE: assert property (illegal_exc_o |=> !illegal_exc_o)
    else $error("illegal-instruction pulse longer than one cycle");
  AST_RET: assert property (s_take |-> ##2 (msw_load_o && saved_return_address_o == $past(next_pc_i, 2)))
    else $error("saved return address wrong");
  AST_SAVED: assert property (s_take |-> ##2 ((saved_machine_state_o & `MSW_SAVE_MASK)
    == ($past(machine_state_word_i, 2) & `MSW_SAVE_MASK)))
    else $error("saved state bits not copied");
  AST_CLEAR: assert property (msw_load_o |-> (msw_new_o & `MSW_CLEAR_MASK) == 32'h00000000)
    else $error("state bits not cleared on entry");
  AST_KEEP: assert property (msw_load_o |-> (msw_new_o[`MSW_ILE] == s.cap_msw[`MSW_ILE]
    && msw_new_o[`MSW_ME] == s.cap_msw[`MSW_ME] && msw_new_o[`MSW_IP] == s.cap_msw[`MSW_IP]
    && msw_new_o[`MSW_LE] == s.cap_msw[`MSW_ILE]))
    else $error("kept bits or endian mode wrong");
  AST_VECTOR: assert property (s_take |-> ##2 s_saved ##0 fetch_addr_o[`VEC_OFF_MSB:0] == `VEC_OFFSET)
    else $error("fetch not redirected to the assist offset");
  AST_BASE: assert property (fetch_redirect_o |-> fetch_addr_o[31:`VEC_BASE_LSB]
    == ($past(msw_new_o[`MSW_IP]) ? `VEC_BASE_HI : `VEC_BASE_LO))
    else $error("vector base does not follow the prefix bit");
  AST_BOUNDARY: assert property ((s.st == ST_IDLE && !instr_boundary_i) |=> s.st == ST_IDLE)
    else $error("entry started off an instruction boundary");
  AST_HOLD: assert property (s_take |=> fp_hold_o [*2])
    else $error("faulting instruction not held during entry");
endmodule

// >>> hw/fpa_map.svh
// offsets, field positions, reset values and fixed addresses of the assist entry block
// assumes a 32-bit machine state word, bit 0 of the vector being the least significant
`ifndef FPA_MAP_SVH
`define FPA_MAP_SVH

// wishbone register byte offsets
`define FPA_REG_CTRL 8'h00
`define FPA_REG_STATUS 8'h04
`define FPA_REG_MASK 8'h08
`define FPA_REG_RET 8'h0C
`define FPA_REG_SAVED 8'h10
`define FPA_REG_VECTOR 8'h14

// control, status and mask fields
`define FPA_CTRL_EN 0
`define FPA_CTRL_ILL 1
`define FPA_CTRL_RST 2'h1
`define FPA_ST_TAKEN 0
`define FPA_ST_ILL 1

// machine state word positions
`define MSW_POW 18
`define MSW_ILE 16
`define MSW_EE 15
`define MSW_PR 14
`define MSW_FP 13
`define MSW_ME 12
`define MSW_FE0 11
`define MSW_SE 10
`define MSW_BE 9
`define MSW_FE1 8
`define MSW_IP 6
`define MSW_IR 5
`define MSW_DR 4
`define MSW_RI 1
`define MSW_LE 0

// copied fields 16-23, 25-27, 30-31 and cleared fields on entry
`define MSW_SAVE_MASK 32'h0000FF73
`define MSW_CLEAR_MASK 32'h0004EF32

// implementation info lands in 1-4 and 10-15
`define IMPL_HI_MSB 9
`define IMPL_HI_LSB 6
`define IMPL_LO_MSB 5
`define IMPL_LO_LSB 0
`define SAVED_HI_MSB 30
`define SAVED_HI_LSB 27
`define SAVED_LO_MSB 21
`define SAVED_LO_LSB 16

// vector: base high part and offset
`define VEC_OFFSET 20'h00E00
`define VEC_BASE_LO 12'h000
`define VEC_BASE_HI 12'hFFF
`define VEC_OFF_MSB 19
`define VEC_BASE_LSB 20

`endif

// >>> hw/fpa_pkg.sv
// types of the assist exception entry block
// assumes fpa_map.svh for all numeric constants
package fpa_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAVE = 3'b010,
    ST_REDIRECT = 3'b100
  } entry_state_t;

  typedef struct packed {
    entry_state_t st;
    logic [31:0] cap_pc;
    logic [31:0] cap_msw;
    logic [9:0] cap_impl;
    logic [31:0] ret;
    logic [31:0] saved;
    logic [31:0] msw_new;
    logic msw_load;
    logic redirect;
    logic [31:0] fetch_addr;
    logic illegal;
    logic hold;
    logic [1:0] ctrl;
    logic [1:0] status;
    logic [1:0] mask;
    logic irq;
    logic ack;
    logic [31:0] dat;
  } entry_regs_t;

endpackage

// >>> hw/fpa_rw_if.sv
// carries the captured state into the rewrite unit and its results back
// assumes both ends sit in one clock domain; the signals are combinational
`timescale 1ns/1ps
interface fpa_rw_if;
  logic [31:0] msw;
  logic [9:0] impl;
  logic [31:0] new_msw;
  logic [31:0] saved;
  logic [31:0] vec;
  modport calc (input msw, input impl, output new_msw, output saved, output vec);
  modport user (output msw, output impl, input new_msw, input saved, input vec);
endinterface

// >>> hw/fpa_state_rewrite.sv
// works out the saved state, the new machine state word and the vector address
// assumes the inputs are held stable by the entry sequencer
`timescale 1ns/1ps
`include "fpa_map.svh"
module fpa_state_rewrite
  import fpa_pkg::*;
(
  fpa_rw_if.calc rw
);
  logic [31:0] clr_msw;

  always_comb begin
    rw.saved = rw.msw & `MSW_SAVE_MASK;
    rw.saved[`SAVED_HI_MSB:`SAVED_HI_LSB] = rw.impl[`IMPL_HI_MSB:`IMPL_HI_LSB];
    rw.saved[`SAVED_LO_MSB:`SAVED_LO_LSB] = rw.impl[`IMPL_LO_MSB:`IMPL_LO_LSB];
    clr_msw = rw.msw & ~`MSW_CLEAR_MASK;
    clr_msw[`MSW_LE] = rw.msw[`MSW_ILE];
    rw.new_msw = clr_msw;
    // ip is kept, so the base follows the same bit before and after entry
    rw.vec = {(rw.msw[`MSW_IP] ? `VEC_BASE_HI : `VEC_BASE_LO), `VEC_OFFSET};
  end
endmodule

// >>> tb/fpa_core_model.sv
// core-side model: raises an assist or unimplemented request and holds it until serviced or 40 cycles pass
// assumes the entry block answers with a state load or an illegal-instruction pulse
`timescale 1ns/1ps
module fpa_core_model (
  input wire logic clk_i,
  input wire logic load_i,
  input wire logic illegal_i,
  output logic assist_o,
  output logic unimpl_o,
  output logic boundary_o,
  output logic [31:0] pc_o,
  output logic [31:0] msw_o,
  output logic [9:0] impl_o
);
  initial begin
    assist_o = 1'b0;
    unimpl_o = 1'b0;
    boundary_o = 1'b0;
    pc_o = 32'h0;
    msw_o = 32'h0;
    impl_o = 10'h0;
  end

  task automatic take(input logic un, input logic [31:0] pc, input logic [31:0] msw, input logic [9:0] impl,
                      input int dly);
    int n;
    @(posedge clk_i);
    assist_o <= ~un;
    unimpl_o <= un;
    pc_o <= pc;
    msw_o <= msw;
    impl_o <= impl;
    // older instructions still running for dly cycles
    repeat (dly) begin
      boundary_o <= 1'b0;
      @(posedge clk_i);
    end
    boundary_o <= 1'b1;
    n = 0;
    // the answer is taken at the rising edge, then the request is released at once
    do begin
      @(posedge clk_i);
      n++;
    end while (load_i !== 1'b1 && illegal_i !== 1'b1 && n < 40);
    assist_o <= 1'b0;
    unimpl_o <= 1'b0;
    boundary_o <= 1'b0;
    // released lines show the inverse, never the last value
    pc_o <= ~pc;
    msw_o <= ~msw;
    impl_o <= ~impl;
  endtask
endmodule

// >>> tb/tb_fp_assist_exception_entry.sv
// testbench of the assist exception entry block
// assumes the core model drives the exception port and the bench is the wishbone master
`timescale 1ns/1ps
module tb_fp_assist_exception_entry;
  typedef struct {logic un; logic [31:0] pc; logic [31:0] msw; logic [9:0] impl; int dly;} row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic wen = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'hF;
  logic [31:0] rd, wb_dat_o, msw_new_o, sra_o, sms_o, fetch_addr_o, pc, msw;
  logic [9:0] impl;
  logic wb_ack_o, irq_o, assist, unimpl, boundary, fp_hold_o, illegal_exc_o, msw_load_o, fetch_redirect_o;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  int n_load = 0;
  row_t rows[4] = '{'{1'b0, 32'h0000_1004, 32'hFFFF_FFFF, 10'h3FF, 0}, '{1'b1, 32'h0000_2008, 32'h0, 10'h000, 3},
                    '{1'b0, 32'hFFF0_0010, 32'hA5A5_5A5A, 10'h2C3, 1}, '{1'b0, 32'h1234_5678, 32'h0001_0040, 10'h155, 5}};

  fp_assist_exception_entry uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(wen), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq_o(irq_o), .fp_assist_req_i(assist), .fp_unimpl_req_i(unimpl), .instr_boundary_i(boundary),
    .next_pc_i(pc), .machine_state_word_i(msw), .impl_info_i(impl), .fp_hold_o(fp_hold_o),
    .illegal_exc_o(illegal_exc_o), .msw_load_o(msw_load_o), .msw_new_o(msw_new_o),
    .saved_return_address_o(sra_o), .saved_machine_state_o(sms_o), .fetch_redirect_o(fetch_redirect_o),
    .fetch_addr_o(fetch_addr_o));
  fpa_core_model core (.clk_i(clk_i), .load_i(msw_load_o), .illegal_i(illegal_exc_o), .assist_o(assist),
    .unimpl_o(unimpl), .boundary_o(boundary), .pc_o(pc), .msw_o(msw), .impl_o(impl));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(negedge clk_i) n_load += (msw_load_o === 1'b1);
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdat);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    wen <= we;
    adr <= a;
    wdat <= wd;
    n = 0;
    // ack and read data are taken at the rising edge, before the slave updates them
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) n_fail++;
    rdat = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic entry_chk(input row_t r);
    logic [31:0] sv, nw;
    int n;
    sv = (r.msw & 32'h0000FF73) | {1'b0, r.impl[9:6], 5'h00, r.impl[5:0], 16'h0000};
    nw = r.msw & ~32'h0004EF32;
    nw[0] = r.msw[16];
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (boundary !== 1'b1 && n < 20);
    repeat (2) @(negedge clk_i);
    chk(msw_load_o, 1'b1);
    chk(fp_hold_o, 1'b1);
    chk(sra_o, r.pc);
    chk(sms_o, sv);
    chk(msw_new_o, nw);
    chk(msw_new_o & 32'h00011041, (r.msw & 32'h00011040) | r.msw[16]);
    @(negedge clk_i);
    chk(fetch_redirect_o, 1'b1);
    chk(fetch_addr_o, {r.msw[6] ? 12'hFFF : 12'h000, 20'h00E00});
    chk(fp_hold_o, 1'b0);
  endtask

  initial begin
    int n, loads;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk(irq_o, 1'b0);
    chk(fetch_redirect_o, 1'b0);
    wb(1'b0, 8'h00, 32'h0, rd);
    chk(rd, 32'h1);
    wb(1'b0, 8'h20, 32'h0, rd);
    chk(rd, 32'h0);
    wb(1'b1, 8'h08, 32'h3, rd);
    foreach (rows[i]) begin
      fork
        core.take(rows[i].un, rows[i].pc, rows[i].msw, rows[i].impl, rows[i].dly);
        entry_chk(rows[i]);
      join
    end
    chk(irq_o, 1'b1);
    wb(1'b0, 8'h14, 32'h0, rd);
    chk(rd, 32'hFFF0_0E00);
    wb(1'b0, 8'h04, 32'h0, rd);
    chk(rd, 32'h1);
    wb(1'b1, 8'h04, 32'h1, rd);
    wb(1'b0, 8'h04, 32'h0, rd);
    chk(rd, 32'h0);
    chk(irq_o, 1'b0);
    // byte lanes on the saved return address
    sel <= 4'h3;
    wb(1'b1, 8'h0C, 32'hDEAD_BEEF, rd);
    sel <= 4'hF;
    wb(1'b0, 8'h0C, 32'h0, rd);
    chk(rd, 32'h1234_BEEF);
    // unimplemented instruction steered to the illegal-instruction exception
    wb(1'b1, 8'h00, 32'h3, rd);
    loads = n_load;
    fork
      core.take(1'b1, 32'h0000_3000, 32'h0000_8000, 10'h0F0, 0);
      begin
        n = 0;
        do begin
          @(negedge clk_i);
          n++;
        end while (illegal_exc_o !== 1'b1 && n < 20);
        chk(illegal_exc_o, 1'b1);
      end
    join
    chk(n_load, loads);
    wb(1'b0, 8'h04, 32'h0, rd);
    chk(rd, 32'h2);
    chk(irq_o, 1'b1);
    // clock enable low: a request is not seen and nothing moves
    @(posedge clk_i);
    ce <= 1'b0;
    core.take(1'b0, 32'h0000_5000, 32'h0000_0040, 10'h002, 0);
    ce <= 1'b1;
    @(negedge clk_i);
    chk(n_load, loads);
    chk(fp_hold_o, 1'b0);
    chk(irq_o, 1'b1);
    // switched off: an assist request is left alone
    wb(1'b1, 8'h00, 32'h0, rd);
    core.take(1'b0, 32'h0000_4000, 32'h0000_0040, 10'h001, 0);
    chk(n_load, loads);
    // reset in mid-run brings back the enabled control value and clears the outputs
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk(irq_o, 1'b0);
    chk(sra_o, 32'h0);
    chk(fetch_addr_o, 32'h0);
    wb(1'b0, 8'h00, 32'h0, rd);
    chk(rd, 32'h1);
    conclude();
  end
endmodule
